/* File: rtl/cspic_params.svh */
// constants for the socket power and interrupt control register pair
// assumes inclusion by bare name from rtl files
`ifndef CSPIC_PARAMS_SVH
`define CSPIC_PARAMS_SVH
// register indices, socket 0 and socket 1
`define CSPIC_IDX_PWR_S0      8'h02
`define CSPIC_IDX_IGC_S0      8'h03
`define CSPIC_IDX_PWR_S1      8'h42
`define CSPIC_IDX_IGC_S1      8'h43
// power control fields
`define CSPIC_PWR_OE_BIT      7
`define CSPIC_PWR_VCC_HI      4
`define CSPIC_PWR_VCC_LO      3
`define CSPIC_PWR_VPP_HI      1
`define CSPIC_PWR_VPP_LO      0
`define CSPIC_PWR_WMASK       8'h9b
// interrupt and general control fields
`define CSPIC_IGC_RING_BIT    7
`define CSPIC_IGC_RST_BIT     6
`define CSPIC_IGC_KIND_BIT    5
`define CSPIC_IGC_ROUTE_BIT   4
`define CSPIC_IGC_SEL_HI      3
`define CSPIC_IGC_SEL_LO      0
// reset values
`define CSPIC_PWR_RESET       8'h00
`define CSPIC_IGC_RESET       8'h00
// irq select codes
`define CSPIC_SEL_NONE        4'h0
`define CSPIC_SEL_SMI         4'h2
`endif

/* File: rtl/cspic_pkg.sv */
// types for the socket power and interrupt control block
// assumes no other package
package cspic_pkg;
   // supply request decode
   typedef enum logic [1:0] {
      CSPIC_VCC_OFF,
      CSPIC_VCC_5V,
      CSPIC_VCC_3V
   } cspic_vcc_t;
   // programming voltage decode
   typedef enum logic [1:0] {
      CSPIC_VPP_OFF,
      CSPIC_VPP_VCC,
      CSPIC_VPP_12V
   } cspic_vpp_t;
endpackage

/* File: rtl/cspic_socket.sv */
// one socket: power control and interrupt/general control registers
// assumes register strobes already decoded for this socket
`timescale 1ns/1ps
`include "cspic_params.svh"
module cspic_socket (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        srst,
   // register access
   input  wire logic        pwr_wr,
   input  wire logic        igc_wr,
   input  wire logic [7:0]  wdata,
   // card-side inputs
   input  wire logic        ring_in,
   input  wire logic        batt_dead_in,
   input  wire logic        card_irq_in,
   input  wire logic        csc_irq_in,
   input  wire logic [3:0]  csc_cfg_route,
   // results
   output logic [7:0]       pwr_q,
   output logic [7:0]       igc_q,
   output cspic_pkg::cspic_vcc_t vcc_sel,
   output cspic_pkg::cspic_vpp_t vpp_sel,
   output logic             power_on,
   output logic             outputs_en,
   output logic             card_reset,
   output logic             ring_mode,
   output logic             status_bit0,
   output logic [15:0]      irq_lines,
   output logic             system_management_interrupt,
   output logic             csc_to_host,
   output logic [15:0]      csc_irq_lines
);
   logic [3:0] sel;
   logic       host_route;

   // power control register, reserved bits kept zero
   always_ff @(posedge clk) begin
      if (srst)
         pwr_q <= `CSPIC_PWR_RESET;
      else if (pwr_wr)
         pwr_q <= wdata & `CSPIC_PWR_WMASK;
   end

   // interrupt and general control register
   always_ff @(posedge clk) begin
      if (srst)
         igc_q <= `CSPIC_IGC_RESET;
      else if (igc_wr)
         igc_q <= wdata;
   end

   // supply decode
   always_comb begin
      unique case (pwr_q[`CSPIC_PWR_VCC_HI:`CSPIC_PWR_VCC_LO])
         2'b10:   vcc_sel = cspic_pkg::CSPIC_VCC_5V;
         2'b11:   vcc_sel = cspic_pkg::CSPIC_VCC_3V;
         default: vcc_sel = cspic_pkg::CSPIC_VCC_OFF;
      endcase
   end

   // programming voltage decode, gated by supply
   always_comb begin
      if (vcc_sel == cspic_pkg::CSPIC_VCC_OFF)
         vpp_sel = cspic_pkg::CSPIC_VPP_OFF;
      else begin
         unique case (pwr_q[`CSPIC_PWR_VPP_HI:`CSPIC_PWR_VPP_LO])
            2'b01:   vpp_sel = cspic_pkg::CSPIC_VPP_VCC;
            2'b10:   vpp_sel = cspic_pkg::CSPIC_VPP_12V;
            default: vpp_sel = cspic_pkg::CSPIC_VPP_OFF;
         endcase
      end
   end

   // status and control levels
   assign power_on    = (vcc_sel != cspic_pkg::CSPIC_VCC_OFF);
   assign outputs_en  = pwr_q[`CSPIC_PWR_OE_BIT];
   assign ring_mode   = igc_q[`CSPIC_IGC_RING_BIT];
   assign card_reset  = ~igc_q[`CSPIC_IGC_RST_BIT];
   assign status_bit0 = ring_mode ? ring_in : batt_dead_in;

   // functional interrupt routing
   assign sel = igc_q[`CSPIC_IGC_SEL_HI:`CSPIC_IGC_SEL_LO];
   always_comb begin
      irq_lines = 16'h0000;
      system_management_interrupt       = 1'b0;
      if (sel == `CSPIC_SEL_SMI)
         system_management_interrupt = card_irq_in;
      else if (sel != `CSPIC_SEL_NONE)
         irq_lines[sel] = card_irq_in;
   end

   // status-change routing
   assign host_route = igc_q[`CSPIC_IGC_ROUTE_BIT] | (sel == `CSPIC_SEL_NONE);
   assign csc_to_host = host_route & csc_irq_in;
   always_comb begin
      csc_irq_lines = 16'h0000;
      if (!host_route && csc_cfg_route != 4'h0)
         csc_irq_lines[csc_cfg_route] = csc_irq_in;
   end
endmodule // cspic_socket

/* File: rtl/cspic_top.sv */
// two-socket power and interrupt/general control register bank
// assumes an indexed byte register port in the host clock domain
`timescale 1ns/1ps
`include "cspic_params.svh"
module cspic_top (
   // clock and reset
   input  wire logic        CORE_CLK,
   input  wire logic        SRST,
   // register port
   input  wire logic [7:0]  REG_INDEX,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   input  wire logic [7:0]  REG_WDATA,
   output logic [7:0]       REG_RDATA,
   // card-side inputs per socket
   input  wire logic [1:0]  BATTERY_DETECT_RING_PIN,
   input  wire logic [1:0]  BATTERY_DEAD_IN,
   input  wire logic [1:0]  CARD_IRQ_IN,
   input  wire logic [1:0]  CSC_IRQ_IN,
   input  wire logic [7:0]  CSC_CFG_ROUTE,
   // card-side controls per socket
   output logic [1:0]       CARD_OUTPUT_ENABLE,
   output logic [1:0]       CARD_RESET,
   output logic [1:0]       RING_INDICATE_ENABLE,
   output logic [1:0]       CARD_KIND_SELECT,
   output logic [1:0]       SOCKET_POWER_ON_STATUS,
   output logic [1:0]       STATUS_BIT0,
   // power switch requests per socket
   output logic [3:0]       SUPPLY_VOLTAGE_REQUEST,
   output logic [3:0]       PROGRAM_VOLTAGE_REQUEST,
   output logic [1:0]       POWER_SWITCH_UPDATE,
   // interrupt routing
   output logic [15:0]      IRQ_LINES,
   output logic             SYSTEM_MANAGEMENT_INTERRUPT,
   output logic             CSC_HOST_IRQ
);
   logic [7:0]  pwr_q [2];
   logic [7:0]  igc_q [2];
   cspic_pkg::cspic_vcc_t vcc_sel [2];
   cspic_pkg::cspic_vpp_t vpp_sel [2];
   logic [1:0]  power_on, oe, rst, ring, sb0, system_management_interrupt, csc_host;
   logic [15:0] irq [2];
   logic [15:0] csc_irq [2];
   logic [3:0]  vcc_d, vpp_d;

   // index decode helper
   function automatic logic hit(input logic [7:0] idx, input logic [7:0] want);
      hit = (idx == want);
   endfunction

   // true when a socket's new requests differ from those last sent
   function automatic logic req_changed(input logic [1:0] vcc_new, input logic [1:0] vpp_new,
                                        input logic [1:0] vcc_old, input logic [1:0] vpp_old);
      req_changed = ({vcc_new, vpp_new} != {vcc_old, vpp_old});
   endfunction

   // both sockets
   for (genvar s = 0; s < 2; s++) begin : g_sock
      logic pwr_wr;
      logic igc_wr;
      // write strobes for this socket's two indices
      assign pwr_wr = REG_WR & hit(REG_INDEX, s ? `CSPIC_IDX_PWR_S1 : `CSPIC_IDX_PWR_S0);
      assign igc_wr = REG_WR & hit(REG_INDEX, s ? `CSPIC_IDX_IGC_S1 : `CSPIC_IDX_IGC_S0);
      cspic_socket u_sock (
         .clk           (CORE_CLK),
         .srst          (SRST),
         .pwr_wr        (pwr_wr),
         .igc_wr        (igc_wr),
         .wdata         (REG_WDATA),
         .ring_in       (BATTERY_DETECT_RING_PIN[s]),
         .batt_dead_in  (BATTERY_DEAD_IN[s]),
         .card_irq_in   (CARD_IRQ_IN[s]),
         .csc_irq_in    (CSC_IRQ_IN[s]),
         .csc_cfg_route (CSC_CFG_ROUTE[4*s +: 4]),
         .pwr_q         (pwr_q[s]),
         .igc_q         (igc_q[s]),
         .vcc_sel       (vcc_sel[s]),
         .vpp_sel       (vpp_sel[s]),
         .power_on      (power_on[s]),
         .outputs_en    (oe[s]),
         .card_reset    (rst[s]),
         .ring_mode     (ring[s]),
         .status_bit0   (sb0[s]),
         .irq_lines     (irq[s]),
         .system_management_interrupt           (system_management_interrupt[s]),
         .csc_to_host   (csc_host[s]),
         .csc_irq_lines (csc_irq[s])
      );
      assign vcc_d[2*s +: 2] = vcc_sel[s];
      assign vpp_d[2*s +: 2] = vpp_sel[s];
   end

   // registered read data, unmapped index reads zero
   always_ff @(posedge CORE_CLK) begin
      if (SRST)
         REG_RDATA <= 8'h00;
      else if (REG_RD) begin
         unique case (REG_INDEX)
            `CSPIC_IDX_PWR_S0: REG_RDATA <= pwr_q[0];
            `CSPIC_IDX_IGC_S0: REG_RDATA <= igc_q[0];
            `CSPIC_IDX_PWR_S1: REG_RDATA <= pwr_q[1];
            `CSPIC_IDX_IGC_S1: REG_RDATA <= igc_q[1];
            default:           REG_RDATA <= 8'h00;
         endcase
      end
   end

   // card output enable follows power bit 7
   always_ff @(posedge CORE_CLK) begin
      if (SRST)
         CARD_OUTPUT_ENABLE <= 2'b00;
      else
         CARD_OUTPUT_ENABLE <= oe;
   end

   // card reset held asserted until software releases it
   always_ff @(posedge CORE_CLK) begin
      if (SRST)
         CARD_RESET <= 2'b11;
      else
         CARD_RESET <= rst;
   end

   // shared battery pin switched to ring indicate
   always_ff @(posedge CORE_CLK) begin
      if (SRST)
         RING_INDICATE_ENABLE <= 2'b00;
      else
         RING_INDICATE_ENABLE <= ring;
   end

   // card kind as programmed by software
   always_ff @(posedge CORE_CLK) begin
      if (SRST)
         CARD_KIND_SELECT <= 2'b00;
      else
         CARD_KIND_SELECT <= {igc_q[1][`CSPIC_IGC_KIND_BIT],
                              igc_q[0][`CSPIC_IGC_KIND_BIT]};
   end

   // power status mirrors the decoded supply request
   always_ff @(posedge CORE_CLK) begin
      if (SRST)
         SOCKET_POWER_ON_STATUS <= 2'b00;
      else
         SOCKET_POWER_ON_STATUS <= power_on;
   end

   // status bit 0: ring level or battery-dead level
   always_ff @(posedge CORE_CLK) begin
      if (SRST)
         STATUS_BIT0 <= 2'b00;
      else
         STATUS_BIT0 <= sb0;
   end

   // supply requests towards the external power switch
   always_ff @(posedge CORE_CLK) begin
      if (SRST)
         SUPPLY_VOLTAGE_REQUEST <= 4'h0;
      else
         SUPPLY_VOLTAGE_REQUEST <= vcc_d;
   end

   // programming requests, already forced off without supply
   always_ff @(posedge CORE_CLK) begin
      if (SRST)
         PROGRAM_VOLTAGE_REQUEST <= 4'h0;
      else
         PROGRAM_VOLTAGE_REQUEST <= vpp_d;
   end

   // one-cycle pulse when a socket's requests differ from those sent
   always_ff @(posedge CORE_CLK) begin
      if (SRST)
         POWER_SWITCH_UPDATE <= 2'b00;
      else begin
         for (int s = 0; s < 2; s++)
            POWER_SWITCH_UPDATE[s] <= req_changed(vcc_d[2*s +: 2], vpp_d[2*s +: 2],
                                                  SUPPLY_VOLTAGE_REQUEST[2*s +: 2],
                                                  PROGRAM_VOLTAGE_REQUEST[2*s +: 2]);
      end
   end

   // legacy lines: functional and status-change routes of both sockets
   always_ff @(posedge CORE_CLK) begin
      if (SRST)
         IRQ_LINES <= 16'h0000;
      else
         IRQ_LINES <= irq[0] | irq[1] | csc_irq[0] | csc_irq[1];
   end

   // system management interrupt from either socket
   always_ff @(posedge CORE_CLK) begin
      if (SRST)
         SYSTEM_MANAGEMENT_INTERRUPT <= 1'b0;
      else
         SYSTEM_MANAGEMENT_INTERRUPT <= |system_management_interrupt;
   end

   // status changes routed to the host bus
   always_ff @(posedge CORE_CLK) begin
      if (SRST)
         CSC_HOST_IRQ <= 1'b0;
      else
         CSC_HOST_IRQ <= |csc_host;
   end
endmodule // cspic_top

/* File: tb/cspic_properties.sv */
// checker on the ports of the socket register bank
// assumes binding onto cspic_top
`timescale 1ns/1ps
module cspic_properties (
   // clock, reset and register port
   input wire logic        CORE_CLK,
   input wire logic        SRST,
   input wire logic [7:0]  REG_INDEX,
   input wire logic        REG_WR,
   input wire logic        REG_RD,
   input wire logic [7:0]  REG_WDATA,
   input wire logic [7:0]  REG_RDATA,
   // card side and results
   input wire logic [1:0]  CARD_IRQ_IN,
   input wire logic [1:0]  CSC_IRQ_IN,
   input wire logic [1:0]  CARD_OUTPUT_ENABLE,
   input wire logic [1:0]  CARD_RESET,
   input wire logic [3:0]  SUPPLY_VOLTAGE_REQUEST,
   input wire logic [3:0]  PROGRAM_VOLTAGE_REQUEST,
   input wire logic [15:0] IRQ_LINES,
   input wire logic        CSC_HOST_IRQ
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (SRST);
   // socket 0 register writes
   sequence pwr_wr0_s; REG_WR && REG_INDEX == 8'h02; endsequence
   sequence igc_wr0_s; REG_WR && REG_INDEX == 8'h03; endsequence
   out_enable_a: assert property (
      pwr_wr0_s |-> ##2 CARD_OUTPUT_ENABLE[0] == $past(REG_WDATA[7], 2)) else $error("oe");
   rsvd_zero_a: assert property (
      REG_RD && REG_INDEX == 8'h42 |=> (REG_RDATA & 8'h64) == 8'h00) else $error("rsvd");
   vpp_off_a: assert property (
      SUPPLY_VOLTAGE_REQUEST[1:0] == 2'h0 |-> PROGRAM_VOLTAGE_REQUEST[1:0] == 2'h0)
      else $error("vpp");
   reset_hold_a: assert property (
      igc_wr0_s |-> ##2 CARD_RESET[0] == !$past(REG_WDATA[6], 2)) else $error("crst");
   reset_vals_a: assert property (@(posedge CORE_CLK) disable iff (1'b0)
      SRST |=> CARD_RESET == 2'h3 && CARD_OUTPUT_ENABLE == 2'h0) else $error("rst");
   unmapped_read_a: assert property (
      REG_RD && REG_INDEX == 8'h01 |=> REG_RDATA == 8'h00) else $error("unmapped");
   irq_cause_a: assert property (
      |IRQ_LINES |-> $past(|(CARD_IRQ_IN | CSC_IRQ_IN))) else $error("irq");
   csc_cause_a: assert property (
      CSC_HOST_IRQ |-> $past(|CSC_IRQ_IN)) else $error("csc");
endmodule // cspic_properties
bind cspic_top cspic_properties u_cspic_properties (.CORE_CLK, .SRST, .REG_INDEX,
   .REG_WR, .REG_RD, .REG_WDATA, .REG_RDATA, .CARD_IRQ_IN, .CSC_IRQ_IN,
   .CARD_OUTPUT_ENABLE, .CARD_RESET, .SUPPLY_VOLTAGE_REQUEST,
   .PROGRAM_VOLTAGE_REQUEST, .IRQ_LINES, .CSC_HOST_IRQ);

/* File: tb/cspic_card_model.sv */
// card sitting in both sockets
// assumes the bench asks for interrupts and pin levels
`timescale 1ns/1ps
module cspic_card_model (
   // requests and levels from the bench
   input wire logic [1:0] irq_req,
   input wire logic [1:0] lvl,
   // socket reset seen by the card
   input wire logic [1:0] card_reset,
   // card pins
   output logic [1:0]     card_irq
);
   // a card held in reset raises no interrupt
   assign card_irq = irq_req & ~card_reset & lvl;
endmodule // cspic_card_model

/* File: tb/testbench.sv */
// self-checking bench for the socket register bank
// assumes cspic_top and the card model
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0;
   logic [7:0] idx = 8'h00, wdat = 8'h00, csc_cfg = 8'h00, rdata;
   logic [1:0] irq_r = 2'h0, csc_r = 2'h0, ring = 2'h0, batt = 2'h0, cirq, oe, crst;
   logic [1:0] rie, kind, pon, sb0, upd;
   logic [3:0] vcc, vpp;
   logic [15:0] irqs;
   logic system_management_interrupt, csch;
   logic [31:0] seed = 32'hc355;
   int num_errors = 0, comparisons = 0, cyc = 0;
   always #4 clk = ~clk;
   cspic_card_model u_cspic_card_model (.irq_req(irq_r), .lvl(2'h3), .card_reset(crst),
      .card_irq(cirq));
   cspic_top u_cspic_top (.CORE_CLK(clk), .SRST(srst), .REG_INDEX(idx), .REG_WR(wr),
      .REG_RD(rd), .REG_WDATA(wdat), .REG_RDATA(rdata), .BATTERY_DETECT_RING_PIN(ring),
      .BATTERY_DEAD_IN(batt), .CARD_IRQ_IN(cirq), .CSC_IRQ_IN(csc_r), .CSC_CFG_ROUTE(csc_cfg),
      .CARD_OUTPUT_ENABLE(oe), .CARD_RESET(crst), .RING_INDICATE_ENABLE(rie),
      .CARD_KIND_SELECT(kind), .SOCKET_POWER_ON_STATUS(pon), .STATUS_BIT0(sb0),
      .SUPPLY_VOLTAGE_REQUEST(vcc), .PROGRAM_VOLTAGE_REQUEST(vpp), .POWER_SWITCH_UPDATE(upd),
      .IRQ_LINES(irqs), .SYSTEM_MANAGEMENT_INTERRUPT(system_management_interrupt), .CSC_HOST_IRQ(csch));
   // xorshift source
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // expected supply and programming requests
   function automatic logic [1:0] e_vcc(input logic [7:0] d);
      return d[4] ? (d[3] ? 2'h2 : 2'h1) : 2'h0;
   endfunction
   function automatic logic [1:0] e_vpp(input logic [7:0] d);
      return (e_vcc(d) == 2'h0 || d[1:0] == 2'h3) ? 2'h0 : d[1:0];
   endfunction
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   // one write, then wait until derived outputs have landed
   task automatic wreg(input logic [7:0] i, input logic [7:0] d);
      @(posedge clk);
      idx <= i;
      wdat <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk); // outputs and the update pulse stand after this edge
      #1;
   endtask
   task automatic rreg(input logic [7:0] i, input logic [7:0] e);
      @(posedge clk);
      idx <= i;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      #1;
      chk("rdata", {8'h00, e}, {8'h00, rdata});
   endtask
   task automatic finish_test();
      $display("comparisons %0d num_errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         finish_test();
      end
   end
   initial begin
      logic [31:0] r;
      logic [7:0] d;
      logic [3:0] pv [2];
      int s;
      logic [3:0] c;
      logic [15:0] ex;
      pv = '{4'h0, 4'h0};
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      rreg(8'h02, 8'h00);
      chk("crst", 16'h3, {14'h0, crst});
      rreg(8'h43, 8'h00);
      $display("test reset done");
      // every supply and vpp code first, reserved bits set, then random
      for (int k = 0; k < 40; k++) begin
         r = rnd();
         s = k % 2;
         d = (k < 16) ? {3'h7, k[3:2], 1'h1, k[1:0]} : r[7:0];
         wreg(s ? 8'h42 : 8'h02, d);
         chk("upd", {e_vcc(d), e_vpp(d)} != pv[s], upd[s]);
         pv[s] = {e_vcc(d), e_vpp(d)};
         chk("oe", d[7], oe[s]);
         chk("vcc", e_vcc(d), vcc[2*s+:2]);
         chk("vpp", e_vpp(d), vpp[2*s+:2]);
         chk("pon", e_vcc(d) != 2'h0, pon[s]);
         rreg(s ? 8'h42 : 8'h02, d & 8'h9b);
      end
      $display("test power done");
      for (int k = 0; k < 16; k++) begin
         r = rnd();
         s = k % 2;
         d = r[15:8];
         @(posedge clk);
         ring <= r[1:0];
         batt <= r[3:2];
         wreg(s ? 8'h43 : 8'h03, d);
         chk("ring", d[7], rie[s]);
         chk("crst", !d[6], crst[s]);
         chk("kind", d[5], kind[s]);
         chk("sb0", d[7] ? r[s] : r[2+s], sb0[s]);
         rreg(s ? 8'h43 : 8'h03, d);
      end
      wreg(8'h01, 8'hff);
      rreg(8'h01, 8'h00);
      $display("test control done");
      // socket 1 held quiet, socket 0 card raises both interrupts
      wreg(8'h43, 8'h00);
      r = rnd();
      c = r[3:0] | 4'h1; // nonzero status-change route for socket 0
      @(posedge clk);
      irq_r <= 2'h1;
      csc_r <= 2'h1;
      csc_cfg <= {4'h0, c};
      for (int k = 0; k < 32; k++) begin
         wreg(8'h03, {3'h3, k[4:0]});
         @(posedge clk);
         #1;
         d = {4'h0, k[3:0]};
         ex = (d == 8'h0 || d == 8'h2) ? 16'h0 : 16'h1 << d;
         ex = ex | ((!k[4] && d != 8'h0) ? 16'h1 << c : 16'h0);
         chk("irq", ex, irqs);
         chk("smi", d == 8'h2, system_management_interrupt);
         chk("csc", k[4] || d == 8'h0, csch);
      end
      $display("test irq done");
      finish_test();
   end
endmodule // testbench
